// file: hdl/arpm_rule_entry_matcher.sv
`timescale 1ns/1ps
`default_nettype none
`include "arpm_defs.svh"

module arpm_rule_entry_matcher
   import arpm_pkg::*;
(
   // Clock and reset
   input  wire logic             sys_clk,
   input  wire logic             sys_rst,
   // Rule entry settings
   input  var  arpm_rule_entry_t rule_entry,
   // Parsed header from the frame parser
   input  wire logic             hdr_valid,
   input  var  arpm_hdr_t        hdr,
   // Decision
   output logic                  decision_valid_r,
   output logic                  entry_match_r,
   output logic                  frame_drop_r
);

   // ----------------------------------------------------------------
   // Decoding helpers
   // ----------------------------------------------------------------
   function automatic logic tri_ok(input arpm_tri_t sel, input logic cond);
      case (sel)
         ARPM_TC_ONE:  tri_ok = cond;
         ARPM_TC_ZERO: tri_ok = !cond;
         default:      tri_ok = 1'b1;
      endcase
   endfunction

   function automatic logic addr_ok(input arpm_addr_mode_t mode,
                                    input logic [31:0]     frame_addr,
                                    input logic [31:0]     cfg_addr,
                                    input logic [31:0]     cfg_mask);
      case (mode)
         ARPM_AF_HOST: addr_ok = (frame_addr == cfg_addr);
         ARPM_AF_NET:  addr_ok = ((frame_addr ^ cfg_addr) & cfg_mask) == 32'h0000_0000;
         default:      addr_ok = 1'b1;
      endcase
   endfunction

   // ----------------------------------------------------------------
   // Opcode classification
   // ----------------------------------------------------------------
   // Opcodes outside the four known codes fall in neither class
   function automatic logic op_in_pair(input logic [15:0] op,
                                       input logic [15:0] code_a,
                                       input logic [15:0] code_b);
      op_in_pair = (op == code_a) || (op == code_b);
   endfunction

   logic op_is_arp;
   logic op_is_rarp;
   logic op_is_req;
   logic op_is_rep;

   always_comb
   begin
      op_is_arp  = op_in_pair(hdr.opcode, `ARPM_OP_ARP_REQ, `ARPM_OP_ARP_REP);
      op_is_rarp = op_in_pair(hdr.opcode, `ARPM_OP_RARP_REQ, `ARPM_OP_RARP_REP);
      op_is_req  = op_in_pair(hdr.opcode, `ARPM_OP_ARP_REQ, `ARPM_OP_RARP_REQ);
      op_is_rep  = op_in_pair(hdr.opcode, `ARPM_OP_ARP_REP, `ARPM_OP_RARP_REP);
   end

   // ----------------------------------------------------------------
   // Frame type gate
   // ----------------------------------------------------------------
   logic ftype_ok;

   always_comb
   begin
      case (rule_entry.frame_type)
         ARPM_FT_ARP:   ftype_ok = hdr.is_arp;
         ARPM_FT_ETYPE: ftype_ok = !hdr.is_arp && !hdr.is_ipv4;
         ARPM_FT_IPV4:  ftype_ok = hdr.is_ipv4;
         default:       ftype_ok = 1'h1;
      endcase
   end

   // ----------------------------------------------------------------
   // Opcode class and direction
   // ----------------------------------------------------------------
   logic opclass_ok;
   logic dir_ok;

   always_comb
   begin
      case (rule_entry.op_class)
         ARPM_OC_ARP:   opclass_ok = op_is_arp;
         ARPM_OC_RARP:  opclass_ok = op_is_rarp;
         ARPM_OC_OTHER: opclass_ok = !op_is_arp && !op_is_rarp;
         default:       opclass_ok = 1'h1;
      endcase

      case (rule_entry.direction)
         ARPM_DIR_REQ: dir_ok = op_is_req;
         ARPM_DIR_REP: dir_ok = op_is_rep;
         default:      dir_ok = 1'h1;
      endcase
   end

   // ----------------------------------------------------------------
   // Protocol address filters
   // ----------------------------------------------------------------
   logic sender_ok;
   logic target_ok;

   // Host mode ignores the mask; network mode compares under it
   always_comb
   begin
      sender_ok = addr_ok(rule_entry.sender_mode, hdr.sender_proto_addr,
                          rule_entry.sender_addr, rule_entry.sender_mask);
      target_ok = addr_ok(rule_entry.target_mode, hdr.target_proto_addr,
                          rule_entry.target_addr, rule_entry.target_mask);
   end

   // ----------------------------------------------------------------
   // Hardware address checks
   // ----------------------------------------------------------------
   logic sha_ok;
   logic tha_ok;

   // Each check binds only its own opcode class, so the other class never trips it
   always_comb
   begin
      sha_ok = !op_is_arp ||
               tri_ok(rule_entry.sender_hw_addr_check,
                      hdr.sender_hw_addr == hdr.frame_source_mac);
      tha_ok = !op_is_rarp ||
               tri_ok(rule_entry.target_hw_addr_check,
                      hdr.target_hw_addr == hdr.frame_source_mac);
   end

   // ----------------------------------------------------------------
   // Length and space checks
   // ----------------------------------------------------------------
   logic len_ok;
   logic hrd_ok;
   logic pro_ok;

   // Lengths conform only when both of them do at once
   always_comb
   begin
      len_ok = tri_ok(rule_entry.addr_length_check,
                      (hdr.hw_len == `ARPM_HW_LEN_ETH) &&
                      (hdr.proto_len == `ARPM_PROTO_LEN_IP));
      hrd_ok = tri_ok(rule_entry.hw_space_check,
                      hdr.hw_type == `ARPM_HW_SPACE_ETH);
      pro_ok = tri_ok(rule_entry.proto_space_check,
                      hdr.proto_type == `ARPM_PROTO_IPV4);
   end

   // ----------------------------------------------------------------
   // Entry verdict
   // ----------------------------------------------------------------
   logic arp_fields_ok;
   logic all_ok;

   // ARP field conditions apply only to ARP entries; other kinds are judged by the frame type gate alone
   always_comb
   begin
      arp_fields_ok = opclass_ok && dir_ok && sender_ok && target_ok &&
                      sha_ok && tha_ok && len_ok && hrd_ok && pro_ok;
      all_ok = ftype_ok &&
               ((rule_entry.frame_type != ARPM_FT_ARP) || arp_fields_ok);
   end

   // ----------------------------------------------------------------
   // Registered decision
   // ----------------------------------------------------------------
   logic decision_valid_nxt;
   logic entry_match_nxt;
   logic frame_drop_nxt;

   // Match and drop hold their last value between strobes so a slow consumer still sees them
   always_comb
   begin
      decision_valid_nxt = hdr_valid;
      entry_match_nxt    = entry_match_r;
      frame_drop_nxt     = frame_drop_r;
      if (hdr_valid)
      begin
         entry_match_nxt = all_ok;
         frame_drop_nxt  = all_ok && rule_entry.action_deny;
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         decision_valid_r <= `ARPM_RST_VALID;
         entry_match_r    <= `ARPM_RST_MATCH;
         frame_drop_r     <= `ARPM_RST_DROP;
      end
      else
      begin
         decision_valid_r <= decision_valid_nxt;
         entry_match_r    <= entry_match_nxt;
         frame_drop_r     <= frame_drop_nxt;
      end
   end

endmodule

`default_nettype wire

// file: include/arpm_defs.svh
`ifndef ARPM_DEFS_SVH
`define ARPM_DEFS_SVH

// ----------------------------------------------------------------
// Opcodes of the address resolution header
// ----------------------------------------------------------------
`define ARPM_OP_ARP_REQ   16'h0001
`define ARPM_OP_ARP_REP   16'h0002
`define ARPM_OP_RARP_REQ  16'h0003
`define ARPM_OP_RARP_REP  16'h0004

// ----------------------------------------------------------------
// Conforming header constants
// ----------------------------------------------------------------
`define ARPM_HW_LEN_ETH   8'h06
`define ARPM_PROTO_LEN_IP 8'h04
`define ARPM_HW_SPACE_ETH 16'h0001
`define ARPM_PROTO_IPV4   16'h0800

// ----------------------------------------------------------------
// Output reset values
// ----------------------------------------------------------------
`define ARPM_RST_MATCH    1'h0
`define ARPM_RST_DROP     1'h0
`define ARPM_RST_VALID    1'h0

`endif

// file: include/arpm_pkg.sv
`default_nettype none
package arpm_pkg;

   // ----------------------------------------------------------------
   // Setting encodings
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {ARPM_FT_ANY, ARPM_FT_ETYPE, ARPM_FT_ARP, ARPM_FT_IPV4} arpm_ftype_t;
   typedef enum logic [1:0] {ARPM_OC_ANY, ARPM_OC_ARP, ARPM_OC_RARP, ARPM_OC_OTHER} arpm_opclass_t;
   typedef enum logic [1:0] {ARPM_DIR_ANY, ARPM_DIR_REQ, ARPM_DIR_REP} arpm_dir_t;
   typedef enum logic [1:0] {ARPM_AF_ANY, ARPM_AF_HOST, ARPM_AF_NET} arpm_addr_mode_t;
   // Tri-state check: require false, require true, or don't-care
   typedef enum logic [1:0] {ARPM_TC_ZERO, ARPM_TC_ONE, ARPM_TC_ANY} arpm_tri_t;

   // ----------------------------------------------------------------
   // Parsed header presented by the frame parser
   // ----------------------------------------------------------------
   typedef struct packed {
      logic        is_arp;
      logic        is_ipv4;
      logic [15:0] opcode;
      logic [15:0] hw_type;
      logic [15:0] proto_type;
      logic [7:0]  hw_len;
      logic [7:0]  proto_len;
      logic [47:0] sender_hw_addr;
      logic [31:0] sender_proto_addr;
      logic [47:0] target_hw_addr;
      logic [31:0] target_proto_addr;
      logic [47:0] frame_source_mac;
   } arpm_hdr_t;

   // ----------------------------------------------------------------
   // Rule entry settings
   // ----------------------------------------------------------------
   typedef struct packed {
      arpm_ftype_t     frame_type;
      logic            action_deny;
      arpm_opclass_t   op_class;
      arpm_dir_t       direction;
      arpm_addr_mode_t sender_mode;
      logic [31:0]     sender_addr;
      logic [31:0]     sender_mask;
      arpm_addr_mode_t target_mode;
      logic [31:0]     target_addr;
      logic [31:0]     target_mask;
      arpm_tri_t       sender_hw_addr_check;
      arpm_tri_t       target_hw_addr_check;
      arpm_tri_t       addr_length_check;
      arpm_tri_t       hw_space_check;
      arpm_tri_t       proto_space_check;
   } arpm_rule_entry_t;

endpackage
`default_nettype wire

// file: tb/arpm_matcher_assertions.sv
`timescale 1ns/1ps
`default_nettype none
`include "arpm_defs.svh"
module arpm_matcher_assertions
   import arpm_pkg::*;
(
   // Clock and reset
   input wire logic             sys_clk,
   input wire logic             sys_rst,
   // Entry and header
   input var  arpm_rule_entry_t rule_entry,
   input wire logic             hdr_valid,
   input var  arpm_hdr_t        hdr,
   // Decision
   input wire logic             decision_valid_r,
   input wire logic             entry_match_r,
   input wire logic             frame_drop_r
);
   // Copies of what was sampled with the header, to judge the decision
   arpm_rule_entry_t pe_r;
   arpm_hdr_t        ph_r;
   wire logic        ad;
   always_ff @(posedge sys_clk)
   begin
      pe_r <= rule_entry;
      ph_r <= hdr;
   end
   assign ad = decision_valid_r && pe_r.frame_type == ARPM_FT_ARP && ph_r.is_arp;
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (sys_rst);
   a_answer_one_late: assert property (hdr_valid |=> decision_valid_r)
      else $error("decision missing");
   a_answer_has_cause: assert property (decision_valid_r |-> $past(hdr_valid))
      else $error("decision without header");
   a_hold_between: assert property (!decision_valid_r && !$past(sys_rst) |->
      $stable(entry_match_r) && $stable(frame_drop_r)) else $error("outputs moved");
   a_drop_needs_deny: assert property (decision_valid_r |->
      frame_drop_r == (entry_match_r && pe_r.action_deny)) else $error("drop wrong");
   a_etype_no_arp: assert property (decision_valid_r && ph_r.is_arp &&
      pe_r.frame_type == ARPM_FT_ETYPE |-> !entry_match_r) else $error("arp hit etype");
   a_sender_host_exact: assert property (ad && pe_r.sender_mode == ARPM_AF_HOST &&
      ph_r.sender_proto_addr != pe_r.sender_addr |-> !entry_match_r) else $error("sender");
   a_target_net_mask: assert property (ad && pe_r.target_mode == ARPM_AF_NET &&
      ((ph_r.target_proto_addr ^ pe_r.target_addr) & pe_r.target_mask) != '0
      |-> !entry_match_r) else $error("target");
   a_length_zero: assert property (ad && pe_r.addr_length_check == ARPM_TC_ZERO &&
      ph_r.hw_len == `ARPM_HW_LEN_ETH && ph_r.proto_len == `ARPM_PROTO_LEN_IP
      |-> !entry_match_r) else $error("length");
endmodule
bind arpm_rule_entry_matcher arpm_matcher_assertions i_chk (.sys_clk(sys_clk),
   .sys_rst(sys_rst), .rule_entry(rule_entry), .hdr_valid(hdr_valid), .hdr(hdr),
   .decision_valid_r(decision_valid_r), .entry_match_r(entry_match_r),
   .frame_drop_r(frame_drop_r));
`default_nettype wire

// file: tb/arpm_parser_model.sv
`timescale 1ns/1ps
`default_nettype none
module arpm_parser_model
   import arpm_pkg::*;
(
   // Clock and request
   input  wire logic      sys_clk,
   input  wire logic      send,
   input  var  arpm_hdr_t hdr_in,
   // Toward the matcher
   output logic           hdr_valid,
   output var  arpm_hdr_t hdr
);
   arpm_hdr_t last_r = '0;
   always_ff @(posedge sys_clk)
   begin
      if (send)
         last_r <= hdr_in;
   end
   // Idle header is the inverse of the last, so stale fields never pass as fresh
   assign hdr_valid = send;
   assign hdr = send ? hdr_in : ~last_r;
endmodule
`default_nettype wire

// file: tb/testbench.sv
`timescale 1ns/1ps
`default_nettype none
`include "arpm_defs.svh"
module testbench;
   import arpm_pkg::*;
   logic             sys_clk = 1'b0;
   logic             sys_rst = 1'b1;
   logic             send = 1'b0;
   arpm_rule_entry_t ent = '0;
   arpm_hdr_t        hin = '0;
   arpm_hdr_t        hdr;
   logic             hdr_valid, dv, em, fd;
   logic             pv = 1'b0, xm = 1'b0, xd = 1'b0;
   int               err_count = 0;
   int               comparisons = 0;
   always #2 sys_clk = ~sys_clk;
   arpm_parser_model i_par (.sys_clk(sys_clk), .send(send), .hdr_in(hin),
      .hdr_valid(hdr_valid), .hdr(hdr));
   arpm_rule_entry_matcher i_dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .rule_entry(ent),
      .hdr_valid(hdr_valid), .hdr(hdr), .decision_valid_r(dv), .entry_match_r(em),
      .frame_drop_r(fd));
   function automatic logic tc(arpm_tri_t t, logic c);
      return (t == ARPM_TC_ZERO) ? !c : (t == ARPM_TC_ONE) ? c : 1'b1;
   endfunction
   function automatic logic ref_m(arpm_rule_entry_t e, arpm_hdr_t h);
      logic a, r, k;
      a = h.opcode inside {`ARPM_OP_ARP_REQ, `ARPM_OP_ARP_REP};
      r = h.opcode inside {`ARPM_OP_RARP_REQ, `ARPM_OP_RARP_REP};
      if (e.frame_type == ARPM_FT_ANY)
         return 1'b1;
      if (e.frame_type == ARPM_FT_ETYPE)
         return !h.is_arp && !h.is_ipv4;
      if (e.frame_type == ARPM_FT_IPV4)
         return h.is_ipv4;
      k = h.is_arp;
      k &= (e.op_class != ARPM_OC_ARP || a) && (e.op_class != ARPM_OC_RARP || r);
      k &= e.op_class != ARPM_OC_OTHER || !(a || r);
      k &= e.direction != ARPM_DIR_REQ || h.opcode inside {16'h1, 16'h3};
      k &= e.direction != ARPM_DIR_REP || h.opcode inside {16'h2, 16'h4};
      k &= e.sender_mode != ARPM_AF_HOST || h.sender_proto_addr == e.sender_addr;
      k &= e.sender_mode != ARPM_AF_NET ||
         ((h.sender_proto_addr ^ e.sender_addr) & e.sender_mask) == '0;
      k &= e.target_mode != ARPM_AF_HOST || h.target_proto_addr == e.target_addr;
      k &= e.target_mode != ARPM_AF_NET ||
         ((h.target_proto_addr ^ e.target_addr) & e.target_mask) == '0;
      k &= !a || tc(e.sender_hw_addr_check, h.sender_hw_addr == h.frame_source_mac);
      k &= !r || tc(e.target_hw_addr_check, h.target_hw_addr == h.frame_source_mac);
      k &= tc(e.addr_length_check, h.hw_len == 8'h06 && h.proto_len == 8'h04);
      k &= tc(e.hw_space_check, h.hw_type == 16'h0001);
      k &= tc(e.proto_space_check, h.proto_type == 16'h0800);
      return k;
   endfunction
   // Fields are pulled toward the entry so that matches are not vanishingly rare
   task automatic gen();
      ent = $bits(ent)'({$urandom, $urandom, $urandom, $urandom, $urandom});
      hin = $bits(hin)'({$urandom, $urandom, $urandom, $urandom, $urandom, $urandom,
         $urandom, $urandom, $urandom});
      if ($urandom % 32'h2)
         ent.frame_type = ARPM_FT_ARP;
      hin.is_arp = ($urandom % 32'h4) != 32'h0;
      hin.opcode = 16'($urandom % 32'h6);
      hin.hw_type = 16'($urandom % 32'h2);
      hin.proto_type = ($urandom % 32'h2) ? 16'h0800 : 16'h0806;
      hin.hw_len = ($urandom % 32'h2) ? 8'h06 : 8'h05;
      hin.proto_len = ($urandom % 32'h2) ? 8'h04 : 8'h10;
      if ($urandom % 32'h2)
         hin.sender_proto_addr = ent.sender_addr;
      if ($urandom % 32'h2)
         hin.target_proto_addr = ent.target_addr;
      if ($urandom % 32'h2)
         hin.sender_hw_addr = hin.frame_source_mac;
      if ($urandom % 32'h2)
         hin.target_hw_addr = hin.frame_source_mac;
   endtask
   // Hand-written corners: class edges, a mask edge, the sender hardware check outside its own class
   task automatic corner(int n);
      ent = '0;
      hin = '0;
      ent.frame_type = ARPM_FT_ARP;
      ent.action_deny = n[0];
      ent.sender_hw_addr_check = ARPM_TC_ANY;
      ent.target_hw_addr_check = ARPM_TC_ANY;
      ent.addr_length_check = ARPM_TC_ANY;
      ent.hw_space_check = ARPM_TC_ONE;
      ent.proto_space_check = ARPM_TC_ONE;
      ent.sender_addr = 32'hC0A8_0101;
      ent.sender_mask = 32'hFFFF_FF00;
      ent.target_addr = 32'hC0A8_01FE;
      hin.is_arp = 1'h1;
      hin.opcode = 16'h0001;
      hin.hw_type = 16'h0001;
      hin.proto_type = 16'h0800;
      hin.hw_len = 8'h06;
      hin.proto_len = 8'h04;
      hin.sender_proto_addr = 32'hC0A8_01FE;
      hin.target_proto_addr = 32'hC0A8_01FF;
      hin.frame_source_mac = 48'h0000_0000_0A01;
      hin.sender_hw_addr = hin.frame_source_mac;
      if (n == 1 || n == 2)
         ent.op_class = ARPM_OC_OTHER;
      if (n == 1)
         hin.opcode = 16'h0005;
      if (n == 2)
         hin.opcode = 16'h0004;
      if (n == 3)
         ent.sender_mode = ARPM_AF_NET;
      if (n == 4)
         ent.target_mode = ARPM_AF_HOST;
      if (n == 5)
         ent.sender_hw_addr_check = ARPM_TC_ZERO;
      if (n == 5)
         hin.opcode = 16'h0003;
      if (n == 6)
         ent.frame_type = ARPM_FT_ETYPE;
      if (n == 7)
         ent.addr_length_check = ARPM_TC_ZERO;
   endtask
   task automatic chk(string n, logic s, logic x);
      comparisons++;
      if (s !== x)
      begin
         err_count++;
         $display("[ERR] %s expected %b seen %b", n, x, s);
      end
   endtask
   task automatic give_verdict();
      $display("comparisons %0d err_count %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   initial
   begin
      void'($urandom(5478));
      repeat (20) @(negedge sys_clk);
      sys_rst = 1'b0;
      for (int i = 0; i < 3000; i++)
      begin
         @(negedge sys_clk);
         chk("decision_valid_r", dv, pv);
         chk("entry_match_r", em, xm);
         chk("frame_drop_r", fd, xd);
         // A reset in mid-run must clear the held decision
         sys_rst = (i == 1500);
         send = !sys_rst && (i < 8 || ($urandom % 32'h4) != 32'h0);
         if (i < 8)
            corner(i);
         else
            gen();
         pv = send;
         if (sys_rst)
            {xm, xd} = 2'h0;
         if (send)
         begin
            xm = ref_m(ent, hin);
            xd = xm && ent.action_deny;
         end
      end
      give_verdict();
   end
endmodule
`default_nettype wire
